// ---- core/pfs_regulator.sv ----
// process feedback selection and regulator front end
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "pfs_defines.svh"

module pfs_regulator
	import pfs_pkg::*;
#(
	parameter int SAMPLE_CYCLES = `PFS_SAMPLE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// process inputs, Q8.8 signed
	input wire logic signed [15:0] analog_fb1,
	input wire logic signed [15:0] analog_fb2,
	// drive side
	input wire logic start_cmd,
	input wire logic current_limit,
	input wire logic voltage_limit,
	input wire logic freq_limit,
	input wire logic [15:0] actual_freq,
	output logic [15:0] freq_cmd,
	output logic regulator_active
);

	// ========================================================
	// functions

	// shape a Q8.8 value: linear, or integer square root kept in Q8.8
	function automatic logic signed [17:0] fb_shape(input logic shape,
		input logic signed [16:0] v);
		logic [23:0] scaled;
		logic [11:0] root;
		logic [11:0] trial;
		scaled = 24'h000000;
		root = 12'h000;
		trial = 12'h000;
		if (!shape) begin
			fb_shape = 18'(v);
		end else begin
			// negative readings have no root; they count as zero
			if (!v[16]) begin
				scaled = {v[15:0], 8'h00};
			end
			for (int i = 11; i >= 0; i--) begin
				trial = root | (12'h001 << i);
				if (24'(trial) * 24'(trial) <= scaled) begin
					root = trial;
				end
			end
			fb_shape = 18'(root);
		end
	endfunction

	// clamp a signed frequency into the output range
	function automatic logic [15:0] freq_clip(input logic signed [39:0] f);
		if (f < 40'sd0) begin
			freq_clip = 16'h0000;
		end else if (f > 40'(`PFS_FREQ_MAX)) begin
			freq_clip = `PFS_FREQ_MAX;
		end else begin
			freq_clip = f[15:0];
		end
	endfunction

	// ========================================================
	// settings written by software
	logic shape_sel;
	logic [3:0] mode_sel;
	logic sense_sel;
	logic clamp_en;
	logic signed [15:0] setpoint1;
	logic signed [15:0] setpoint2;
	logic signed [15:0] remote_ref;
	logic signed [15:0] bus_fb1;
	logic signed [15:0] bus_fb2;
	logic [15:0] handover_frequency;
	logic [9:0] proportional_factor;
	logic [19:0] integral_time_constant;

	// register writes; unmapped offsets are ignored
	always_ff @(posedge clk) begin
		if (rst) begin
			shape_sel <= 1'b0;
			mode_sel <= `PFS_RST_MODE;
			sense_sel <= 1'b0;
			clamp_en <= `PFS_RST_CLAMP;
			setpoint1 <= `PFS_RST_SETPOINT;
			setpoint2 <= `PFS_RST_SETPOINT;
			remote_ref <= 16'h0000;
			bus_fb1 <= 16'h0000;
			bus_fb2 <= 16'h0000;
			handover_frequency <= `PFS_RST_HANDOVER;
			proportional_factor <= `PFS_RST_PROP;
			integral_time_constant <= `PFS_RST_INTEG;
		end else if (reg_wr) begin
			case (reg_addr)
				`PFS_OFS_CONTROL: begin
					shape_sel <= reg_wdata[`PFS_CTL_SHAPE];
					mode_sel <= reg_wdata[`PFS_CTL_MODE_LO +: 4];
					sense_sel <= reg_wdata[`PFS_CTL_SENSE];
					clamp_en <= reg_wdata[`PFS_CTL_CLAMP];
				end
				`PFS_OFS_SETPOINT1: setpoint1 <= reg_wdata[15:0];
				`PFS_OFS_SETPOINT2: setpoint2 <= reg_wdata[15:0];
				`PFS_OFS_REMOTE_REF: remote_ref <= reg_wdata[15:0];
				`PFS_OFS_BUS_FB1: bus_fb1 <= reg_wdata[15:0];
				`PFS_OFS_BUS_FB2: bus_fb2 <= reg_wdata[15:0];
				`PFS_OFS_HANDOVER: handover_frequency <= reg_wdata[15:0];
				`PFS_OFS_PROP: begin
					// factor above 10.00 is held at 10.00
					if (reg_wdata[9:0] > `PFS_PROP_MAX || |reg_wdata[31:10]) begin
						proportional_factor <= `PFS_PROP_MAX;
					end else begin
						proportional_factor <= reg_wdata[9:0];
					end
				end
				`PFS_OFS_INTEG: integral_time_constant <= reg_wdata[19:0];
				default: begin
				end
			endcase
		end
	end

	// ========================================================
	// sample timer
	logic [23:0] tick_count;
	logic tick;

	always_ff @(posedge clk) begin
		if (rst || tick) begin
			tick_count <= 24'h000000;
		end else begin
			tick_count <= tick_count + 24'h000001;
		end
	end
	assign tick = (tick_count == 24'(SAMPLE_CYCLES - 1));

	// ========================================================
	// snapshot at the sample boundary, so a mode change never
	// meets operands of the old one
	logic snap_shape;
	logic [3:0] snap_mode;
	logic snap_sense;
	logic snap_clamp;
	logic signed [15:0] snap_sp1;
	logic signed [15:0] snap_sp2;
	logic signed [15:0] snap_rref;
	logic signed [16:0] snap_fb1;
	logic signed [16:0] snap_fb2;
	logic signed [15:0] snap_an1;
	logic signed [15:0] snap_an2;
	logic step;

	always_ff @(posedge clk) begin
		if (rst) begin
			snap_shape <= 1'b0;
			snap_mode <= `PFS_RST_MODE;
			snap_sense <= 1'b0;
			snap_clamp <= `PFS_RST_CLAMP;
			snap_sp1 <= 16'h0000;
			snap_sp2 <= 16'h0000;
			snap_rref <= 16'h0000;
			snap_fb1 <= 17'h00000;
			snap_fb2 <= 17'h00000;
			snap_an1 <= 16'h0000;
			snap_an2 <= 16'h0000;
			step <= 1'b0;
		end else begin
			step <= tick;
			if (tick) begin
				snap_shape <= shape_sel;
				snap_mode <= mode_sel;
				snap_sense <= sense_sel;
				snap_clamp <= clamp_en;
				snap_sp1 <= setpoint1;
				snap_sp2 <= setpoint2;
				snap_rref <= remote_ref;
				snap_fb1 <= 17'(bus_fb1) + 17'(analog_fb1);
				snap_fb2 <= 17'(bus_fb2) + 17'(analog_fb2);
				snap_an1 <= analog_fb1;
				snap_an2 <= analog_fb2;
			end
		end
	end

	// ========================================================
	// feedback combination and error forming
	logic signed [17:0] fb1_val;
	logic signed [17:0] fb2_val;
	logic signed [19:0] zone1_diff;
	logic signed [19:0] zone2_diff;
	logic signed [19:0] next_fb;
	logic signed [19:0] next_ref;
	logic signed [19:0] raw_err;
	logic signed [19:0] next_err;

	assign fb1_val = fb_shape(snap_shape, snap_fb1);
	assign fb2_val = fb_shape(snap_shape, snap_fb2);
	assign zone1_diff = 20'(snap_sp1) - 20'(fb1_val);
	assign zone2_diff = 20'(snap_sp2) - 20'(fb2_val);

	always_comb begin
		next_fb = 20'(fb1_val);
		next_ref = 20'(snap_sp1) + 20'(snap_rref);
		case (pfs_mode_t'(snap_mode))
			PFS_MIN: next_fb = (fb1_val < fb2_val) ? 20'(fb1_val) : 20'(fb2_val);
			PFS_MAX: next_fb = (fb1_val > fb2_val) ? 20'(fb1_val) : 20'(fb2_val);
			PFS_SUM: next_fb = 20'(fb1_val) + 20'(fb2_val);
			PFS_DIFF: next_fb = 20'(fb2_val) - 20'(fb1_val);
			PFS_AVG: next_fb = (20'(fb1_val) + 20'(fb2_val)) >>> 1;
			PFS_ZONE_MIN: begin
				// signed compare puts any positive difference above a negative one
				if (zone2_diff > zone1_diff) begin
					next_fb = 20'(fb2_val);
					next_ref = 20'(snap_sp2) + 20'(snap_rref);
				end
			end
			PFS_ZONE_MAX: begin
				if (zone2_diff < zone1_diff) begin
					next_fb = 20'(fb2_val);
					next_ref = 20'(snap_sp2) + 20'(snap_rref);
				end
			end
			PFS_FB1_ONLY: next_fb = 20'(fb_shape(snap_shape, 17'(snap_an1)));
			PFS_FB2_ONLY: begin
				next_fb = 20'(fb_shape(snap_shape, 17'(snap_an2)));
				next_ref = 20'(snap_sp2) + 20'(snap_rref);
			end
			default: begin
			end
		endcase
		raw_err = next_ref - next_fb;
		// inverse sense turns the error round
		next_err = snap_sense ? -raw_err : raw_err;
	end

	// ========================================================
	// run sequence: open loop ramp, then regulation
	pfs_state_t state;
	logic [15:0] ramp_freq;
	logic at_limit;

	assign at_limit = current_limit || voltage_limit || freq_limit;

	always_ff @(posedge clk) begin
		if (rst || !start_cmd) begin
			state <= PFS_IDLE;
			ramp_freq <= 16'h0000;
		end else begin
			case (state)
				PFS_IDLE: state <= PFS_RAMP;
				PFS_RAMP: begin
					// compared live, so lowering the target while stuck releases it
					if (ramp_freq >= handover_frequency) begin
						state <= PFS_REGULATE;
					end else if (step && !current_limit) begin
						if (handover_frequency - ramp_freq > `PFS_RAMP_STEP) begin
							ramp_freq <= ramp_freq + `PFS_RAMP_STEP;
						end else begin
							ramp_freq <= handover_frequency;
						end
					end
				end
				PFS_REGULATE: begin
				end
				default: state <= PFS_IDLE;
			endcase
		end
	end

	// ========================================================
	// regulator core; integrator holds frequency in Q16
	logic signed [39:0] integ;
	logic signed [19:0] last_err;
	logic hold_off;
	logic signed [39:0] p_term;
	logic signed [63:0] i_step;
	logic signed [39:0] sum_freq;
	logic [15:0] reg_freq;
	logic sign_ok;

	// proportional part in output frequency units
	assign p_term = ($signed(40'(proportional_factor)) * 40'(next_err)) / 40'sd100;
	// integral gain equals proportional after one integral time
	assign i_step = (integral_time_constant == 20'h00000) ? 64'sd0 :
		(($signed(64'(proportional_factor)) * 64'(next_err)) <<< 16) /
		($signed(64'(integral_time_constant)) * 64'(`PFS_INT_SCALE));
	assign sum_freq = (integ >>> 16) + p_term;
	// re-engage once the error reaches zero or changes sign
	assign sign_ok = (next_err == 20'sd0) || (next_err[19] != last_err[19]);

	always_ff @(posedge clk) begin
		if (rst || state != PFS_REGULATE) begin
			// bumpless entry at the ramp end frequency
			integ <= 40'(ramp_freq) <<< 16;
			last_err <= 20'sd0;
			hold_off <= 1'b0;
		end else if (step) begin
			if (snap_clamp && at_limit) begin
				integ <= 40'(actual_freq) <<< 16;
				last_err <= next_err;
				hold_off <= 1'b1;
			end else if (hold_off) begin
				if (sign_ok) begin
					hold_off <= 1'b0;
				end
				last_err <= next_err;
			end else begin
				// without the clamp the sum runs on and must unwind
				integ <= integ + 40'(i_step);
				last_err <= next_err;
			end
		end
	end

	assign reg_freq = freq_clip(sum_freq);

	// output frequency register
	always_ff @(posedge clk) begin
		if (rst) begin
			freq_cmd <= 16'h0000;
		end else begin
			case (state)
				PFS_REGULATE: begin
					if (hold_off) begin
						freq_cmd <= actual_freq;
					end else if (step) begin
						freq_cmd <= reg_freq;
					end
				end
				PFS_RAMP: freq_cmd <= ramp_freq;
				default: freq_cmd <= 16'h0000;
			endcase
		end
	end

	// regulator engaged flag
	always_ff @(posedge clk) begin
		if (rst) begin
			regulator_active <= 1'b0;
		end else begin
			regulator_active <= (state == PFS_REGULATE) && !hold_off;
		end
	end

	// ========================================================
	// captured results for software
	logic signed [19:0] seen_fb;
	logic signed [19:0] seen_err;

	always_ff @(posedge clk) begin
		if (rst) begin
			seen_fb <= 20'sd0;
			seen_err <= 20'sd0;
		end else if (step) begin
			seen_fb <= next_fb;
			seen_err <= next_err;
		end
	end

	// ========================================================
	// register reads, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`PFS_OFS_CONTROL: reg_rdata <= {25'h0000000, clamp_en, sense_sel,
					mode_sel, shape_sel};
				`PFS_OFS_SETPOINT1: reg_rdata <= 32'(setpoint1);
				`PFS_OFS_SETPOINT2: reg_rdata <= 32'(setpoint2);
				`PFS_OFS_REMOTE_REF: reg_rdata <= 32'(remote_ref);
				`PFS_OFS_BUS_FB1: reg_rdata <= 32'(bus_fb1);
				`PFS_OFS_BUS_FB2: reg_rdata <= 32'(bus_fb2);
				`PFS_OFS_HANDOVER: reg_rdata <= {16'h0000, handover_frequency};
				`PFS_OFS_PROP: reg_rdata <= {22'h000000, proportional_factor};
				`PFS_OFS_INTEG: reg_rdata <= {12'h000, integral_time_constant};
				`PFS_OFS_STATUS: reg_rdata <= {27'h0000000, at_limit, hold_off,
					regulator_active, state};
				`PFS_OFS_FEEDBACK: reg_rdata <= 32'(seen_fb);
				`PFS_OFS_ERROR: reg_rdata <= 32'(seen_err);
				`PFS_OFS_OUTPUT: reg_rdata <= {16'h0000, freq_cmd};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule

// ---- core/pfs_defines.svh ----
// constants of the process feedback and regulator front end
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
// Notes on behaviour
// - shaping code 0 keeps feedback linear, code 1 takes its square root.
// - feedback one is bus feedback word one plus analogue input one.
// - feedback two is bus feedback word two plus analogue input two.
// - combine mode 0 regulates on the lower of both feedbacks.
// - combine mode 1, the default, regulates on the higher feedback.
// - mode 2 regulates on the sum; remote reference joins setpoint one.
// - mode 3 regulates on feedback two minus feedback one.
// - mode 4 regulates on the mean; remote reference joins setpoint one.
// - mode 5 takes the larger zone difference, positive beats negative.
// - in mode 5 remote reference joins the setpoint of the chosen zone.
// - mode 6 takes the smaller zone difference, negative beats positive.
// - in mode 6 remote reference joins the setpoint of the chosen zone.
// - mode 7 uses analogue input one only, against setpoint one.
// - mode 8 uses analogue input two only, against setpoint two.
// - setpoint two serves the zone modes and mode 8; both setpoints reset to zero.
// - normal sense lowers output as feedback rises; inverse raises it.
// - clamp on: at a limit integrator takes actual frequency, waits for sign.
// - clamp off: integrator keeps integrating at a limit.
// - start ramps open loop to handover frequency, then closes the loop.
// - current limit before handover keeps regulator off; lowering it releases.
// - error times proportional factor, 0.00 to 10.00, default 0.01.
// - integrator rises with error over integral time; zero means off.

// ========================================================
// register byte offsets
`define PFS_OFS_CONTROL 8'h00
`define PFS_OFS_SETPOINT1 8'h04
`define PFS_OFS_SETPOINT2 8'h08
`define PFS_OFS_REMOTE_REF 8'h0C
`define PFS_OFS_BUS_FB1 8'h10
`define PFS_OFS_BUS_FB2 8'h14
`define PFS_OFS_HANDOVER 8'h18
`define PFS_OFS_PROP 8'h1C
`define PFS_OFS_INTEG 8'h20
`define PFS_OFS_STATUS 8'h24
`define PFS_OFS_FEEDBACK 8'h28
`define PFS_OFS_ERROR 8'h2C
`define PFS_OFS_OUTPUT 8'h30

// ========================================================
// control fields and reset values
`define PFS_CTL_SHAPE 0
`define PFS_CTL_MODE_LO 1
`define PFS_CTL_SENSE 5
`define PFS_CTL_CLAMP 6
`define PFS_RST_MODE 4'h1
`define PFS_RST_CLAMP 1'h1
`define PFS_RST_PROP 10'h001
`define PFS_RST_INTEG 20'h00000
`define PFS_RST_HANDOVER 16'h0000
`define PFS_RST_SETPOINT 16'h0000
`define PFS_PROP_MAX 10'h3E8

// ========================================================
// timing and scaling
`define PFS_CLK_MHZ 20
`define PFS_SAMPLE_TIME_US 1000
`define PFS_SAMPLE_CYCLES (`PFS_SAMPLE_TIME_US * `PFS_CLK_MHZ)
`define PFS_INT_SCALE (1000000 / `PFS_SAMPLE_TIME_US)
`define PFS_RAMP_STEP 16'h0010
`define PFS_FREQ_MAX 16'hFFFF
`endif

// ---- core/pfs_pkg.sv ----
// types of the process feedback and regulator front end
package pfs_pkg;
	// feedback combine modes
	typedef enum logic [3:0] {
		PFS_MIN, PFS_MAX, PFS_SUM, PFS_DIFF, PFS_AVG,
		PFS_ZONE_MIN, PFS_ZONE_MAX, PFS_FB1_ONLY, PFS_FB2_ONLY
	} pfs_mode_t;
	// sequence of a run
	typedef enum logic [1:0] {PFS_IDLE, PFS_RAMP, PFS_REGULATE} pfs_state_t;
endpackage

// ---- testbench/pfs_regulator_checker.sv ----
// port assertions for the process feedback regulator
`timescale 1ns/1ps
module pfs_regulator_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// drive side
	input wire logic start_cmd,
	input wire logic current_limit,
	input wire logic [15:0] freq_cmd,
	input wire logic regulator_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [15:0] last_wd;
	// ========================================
	// helper: last written low half, for read-back
	always_ff @(posedge clk) begin
		if (reg_wr) last_wd <= reg_wdata[15:0];
	end
	// ========================================
	// assertions
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read cycle");
	AST_UNMAPPED: assert property ($past(reg_rd) && $past(reg_addr) == 8'h3C |-> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	AST_RESET_OUT: assert property (disable iff (1'b0) rst |=> freq_cmd == 16'h0 && !regulator_active)
		else $error("outputs not cleared by reset");
	AST_IDLE_OUT: assert property (!start_cmd [*2] |=> freq_cmd == 16'h0 && !regulator_active)
		else $error("output not zero after stop");
	AST_ACTIVE_START: assert property (regulator_active |-> $past(start_cmd, 2) && $past(start_cmd, 3))
		else $error("regulator active without start");
	AST_FREQ_READ: assert property ($past(reg_rd) && $past(reg_addr) == 8'h30 |-> reg_rdata == {16'h0, $past(freq_cmd)})
		else $error("frequency register mismatch");
	AST_PROP_CAP: assert property (reg_wr && reg_addr == 8'h1C && reg_wdata > 32'h3E8 ##1 reg_rd && reg_addr == 8'h1C |=> reg_rdata == 32'h3E8)
		else $error("gain not capped");
	AST_SP_BACK: assert property (reg_wr && reg_addr == 8'h04 ##1 reg_rd && reg_addr == 8'h04 |=> reg_rdata == {{16{last_wd[15]}}, last_wd})
		else $error("setpoint read-back not sign extended");
	AST_RAMP_HOLD: assert property (start_cmd && $past(start_cmd) && current_limit && $past(current_limit) && !regulator_active && !$past(regulator_active) |-> $stable(freq_cmd))
		else $error("ramp moved at current limit");
	// main scenarios reached
	cover property (regulator_active && current_limit);
	cover property ($fell(regulator_active) && start_cmd);
	cover property ($past(reg_rd) && $past(reg_addr) == 8'h30);
endmodule

bind pfs_regulator pfs_regulator_checker u_chk (
	.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_cmd(start_cmd),
	.current_limit(current_limit), .freq_cmd(freq_cmd), .regulator_active(regulator_active)
);

// ---- testbench/pfs_drive_model.sv ----
// model of the motor output stage facing the regulator
`timescale 1ns/1ps
module pfs_drive_model (
	// clock
	input wire logic clk,
	// limit requests: bit0 current, bit1 voltage, bit2 frequency
	input wire logic [2:0] lim_req,
	input wire logic [15:0] lim_freq,
	input wire logic [15:0] freq_cmd,
	// stage status back to the regulator
	output logic current_limit,
	output logic voltage_limit,
	output logic freq_limit,
	output logic [15:0] actual_freq
);
	// at a limit the stage cannot follow, speed sticks at the limit value
	always_ff @(posedge clk) begin
		actual_freq <= (|lim_req) ? lim_freq : freq_cmd;
	end
	// limit flags are levels of the stage
	assign current_limit = lim_req[0];
	assign voltage_limit = lim_req[1];
	assign freq_limit = lim_req[2];
endmodule

// ---- testbench/tb_process_feedback_pid_selector.sv ----
// self-checking bench for the process feedback regulator
`timescale 1ns/1ps
module tb_process_feedback_pid_selector;
	localparam int SC = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic signed [15:0] analog_fb1 = 16'h0000;
	logic signed [15:0] analog_fb2 = 16'h0000;
	logic start_cmd = 1'b0;
	logic [2:0] lim_req = 3'h0;
	logic [15:0] lim_freq = 16'h0123;
	logic current_limit, voltage_limit, freq_limit;
	logic [15:0] actual_freq, freq_cmd;
	logic regulator_active;
	logic [31:0] rv;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	// ========================================
	// design and output stage
	pfs_regulator #(.SAMPLE_CYCLES(SC)) dut (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.analog_fb1(analog_fb1), .analog_fb2(analog_fb2), .start_cmd(start_cmd),
		.current_limit(current_limit), .voltage_limit(voltage_limit),
		.freq_limit(freq_limit), .actual_freq(actual_freq), .freq_cmd(freq_cmd),
		.regulator_active(regulator_active)
	);
	pfs_drive_model u_drive (
		.clk(clk), .lim_req(lim_req), .lim_freq(lim_freq), .freq_cmd(freq_cmd),
		.current_limit(current_limit), .voltage_limit(voltage_limit),
		.freq_limit(freq_limit), .actual_freq(actual_freq)
	);
	// 20 MHz clock
	always #25 clk = ~clk;
	// ========================================
	// bus and compare helpers
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge clk);
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
		end
	endtask
	// strobe left high so a next access may follow with no gap
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a, rv);
		chk(nm, e, rv);
	endtask
	// ========================================
	// scenarios
	task automatic t_regs();
		rchk("control", 8'h00, 32'h42);
		rchk("prop", 8'h1C, 32'h1);
		rchk("integ", 8'h20, 32'h0);
		rchk("sp1", 8'h04, 32'h0);
		rchk("sp2", 8'h08, 32'h0);
		rchk("handover", 8'h18, 32'h0);
		rchk("unmapped", 8'h3C, 32'h0);
		wr(8'h1C, 32'h7D0);
		rchk("prop cap", 8'h1C, 32'h3E8);
		wr(8'h04, 32'hFF80);
		rchk("sp1 sign", 8'h04, 32'hFFFFFF80);
	endtask
	// gain 1.00 with integrator off, so the command equals a positive error and is zero otherwise
	task automatic mcase(input logic [6:0] ctl, input logic [15:0] b1, a1, b2, a2,
		input logic [31:0] efb, input logic cfb, input logic [31:0] eer);
		wr(8'h00, {25'h0, ctl});
		wr(8'h10, {16'h0, b1});
		wr(8'h14, {16'h0, b2});
		analog_fb1 <= a1;
		analog_fb2 <= a2;
		cyc(2 * SC + 4);
		if (cfb) rchk("feedback", 8'h28, efb);
		rchk("error", 8'h2C, eer);
		chk("freq_cmd", $signed(eer) > 0 ? {16'h0, eer[15:0]} : 32'h0, {16'h0, freq_cmd});
	endtask
	task automatic t_modes();
		wr(8'h1C, 32'h64);
		wr(8'h04, 32'h400);
		wr(8'h08, 32'h50);
		wr(8'h0C, 32'h10);
		start_cmd <= 1'b1;
		mcase(7'h40, 16'h100, 16'h200, 16'h80, 16'h80, 32'h100, 1'h1, 32'h310);
		mcase(7'h42, 16'h100, 16'h200, 16'h80, 16'h80, 32'h300, 1'h1, 32'h110);
		mcase(7'h44, 16'h100, 16'h200, 16'h80, 16'h80, 32'h400, 1'h1, 32'h10);
		mcase(7'h46, 16'h100, 16'h200, 16'h80, 16'h80, 32'hFFFFFE00, 1'h1, 32'h610);
		mcase(7'h48, 16'h100, 16'h200, 16'h80, 16'h80, 32'h200, 1'h1, 32'h210);
		mcase(7'h4A, 16'h100, 16'h200, 16'h80, 16'h80, 32'h300, 1'h1, 32'h110);
		mcase(7'h4C, 16'h100, 16'h200, 16'h80, 16'h80, 32'h100, 1'h1, 32'hFFFFFF60);
		mcase(7'h4E, 16'h100, 16'h200, 16'h80, 16'h80, 32'h200, 1'h1, 32'h210);
		mcase(7'h50, 16'h100, 16'h200, 16'h80, 16'h80, 32'h80, 1'h1, 32'hFFFFFFE0);
		mcase(7'h62, 16'h100, 16'h200, 16'h80, 16'h80, 32'h300, 1'h1, 32'hFFFFFEF0);
		mcase(7'h43, 16'h0, 16'h400, 16'h80, 16'h80, 32'h200, 1'h1, 32'h210);
	endtask
	task automatic t_windup();
		@(posedge clk);
		lim_req <= 3'h2;
		cyc(2 * SC + 4);
		chk("held freq", 32'h123, {16'h0, freq_cmd});
		chk("held active", 32'h0, {31'h0, regulator_active});
		rchk("freq reg", 8'h30, 32'h123);
		@(posedge clk);
		lim_req <= 3'h0;
		cyc(2 * SC + 4);
		chk("still held", 32'h0, {31'h0, regulator_active});
		wr(8'h04, 32'h0);
		cyc(2 * SC + 4);
		chk("released", 32'h1, {31'h0, regulator_active});
		wr(8'h00, 32'h3);
		// let the clamp-off setting reach a sample before the limit arrives
		cyc(SC + 2);
		lim_req <= 3'h4;
		cyc(2 * SC + 4);
		chk("clamp off", 32'h1, {31'h0, regulator_active});
	endtask
	task automatic t_startup();
		start_cmd <= 1'b0;
		cyc(3);
		chk("stop freq", 32'h0, {16'h0, freq_cmd});
		wr(8'h18, 32'h30);
		lim_req <= 3'h1;
		start_cmd <= 1'b1;
		cyc(5 * SC + 4);
		chk("blocked freq", 32'h0, {16'h0, freq_cmd});
		rd(8'h24, rv);
		chk("blocked state", 32'h1, {30'h0, rv[1:0]});
		wr(8'h18, 32'h0);
		cyc(2 * SC + 4);
		chk("released state", 32'h1, {31'h0, regulator_active});
		start_cmd <= 1'b0;
		lim_req <= 3'h0;
		wr(8'h18, 32'h30);
		cyc(3);
		start_cmd <= 1'b1;
		cyc(SC);
		rd(8'h24, rv);
		chk("ramp state", 32'h1, {30'h0, rv[1:0]});
		cyc(5 * SC);
		rd(8'h24, rv);
		chk("closed state", 32'h2, {30'h0, rv[1:0]});
		// positive error with integral time 0.01 s keeps raising the command
		wr(8'h04, 32'h400);
		wr(8'h20, 32'h1);
		cyc(2 * SC + 4);
		rv = {16'h0, freq_cmd};
		cyc(2 * SC);
		chk("integ rises", 32'h1, {31'h0, freq_cmd > rv[15:0]});
	endtask
	// ========================================
	// run and verdict
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_modes();
		t_windup();
		t_startup();
		close_out();
	end
	// hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			close_out();
		end
	end
endmodule
